// [rtl/sbc_top.sv]
/*
  Serial bus control block: the control register, slave address matching,
  slave clock stretching and pin ownership of a two-wire bus port.
  Assumes a register master on clk_sys and open-drain bus lines resolved
  outside; the line levels are sampled by sbc_pin_sync.
*/
// The address map and the plain strobed port were left to the implementer.
// Behaviour
// (RULE1) Enable bit runs port, owns bus pins.
// (RULE2) Halt-in-idle stops port during chip idle.
// (RULE3) Release bit clear holds clock low.
// (RULE4) Stretch enabled: software clears/sets; hardware clears twice.
// (RULE5) Stretch disabled: software only sets release.
// (RULE6) Strict mode ignores reserved slave addresses.
// (RULE7) Wide mode matches 10-bit slave address.
// (RULE8) Slew-disable bit turns off slew limiting.
// (RULE9) SMBus bit selects SMBus input thresholds.
// (RULE10) Bits 31-16 and 14 read zero.
// (RULE11) Software avoids access right after disabling.
// (RULE12) Disabled port releases lines, slave idles.
`timescale 1ns/100ps
module sbc_top import sbc_pkg::*; #(
  parameter int AW = SBC_AW
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Chip power state.
  input wire logic chip_idle,
  // Bus clock line.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Bus data line.
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Pad control.
  output logic pins_owned,
  output logic slew_limit_off,
  output logic smbus_levels_select
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [9:0] saddr;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic rx_full;
    sbc_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic ten_ok;
    logic sda_low;
    logic scl_low;
    logic [31:0] rdata;
  } sbc_regs_t;

  sbc_regs_t r_q;
  sbc_regs_t r_d;

  sbc_pin_if pins ();

  // Line sampler and event finder.
  sbc_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .pins(pins)
  );

  // Seven-bit addresses 0000xxx and 1111xxx are kept for special use.
  function automatic logic sbc_reserved(input logic [6:0] a);
    sbc_reserved = (a[6:3] == 4'h0) || (a[6:3] == 4'hf);
  endfunction

  // Byte offset decode, shared by the read and the write paths.
  function automatic logic sbc_hit(input logic [AW-1:0] a, input logic [7:0] ofs);
    sbc_hit = (a == AW'(ofs));
  endfunction

  // Status word: receive flag, direction and slave state.
  function automatic logic [31:0] sbc_status(input sbc_regs_t r);
    sbc_status = {22'h000000, r.ten_ok, r.rw, r.rx_full, r.nack, 2'h0, r.st};
  endfunction

  logic active;
  logic addressed;

  // The port runs only while enabled and not halted by chip idle.
  assign active = r_q.ctrl[SBC_ON_BIT]
                  & ~(r_q.ctrl[SBC_HALT_BIT] & chip_idle); // (RULE1) (RULE2)
  assign addressed = (r_q.st == SBC_AACK) || (r_q.st == SBC_RX) ||
                     (r_q.st == SBC_RACK) || (r_q.st == SBC_TX) ||
                     (r_q.st == SBC_TACK);

  // Register access, slave sequencing and line drive, all into one copy.
  always_comb begin
    logic rel_clr;
    logic rx_set;
    logic [2:0] bit_idx;
    logic [6:0] a7;
    rel_clr = 1'b0;
    rx_set = 1'b0;
    bit_idx = 3'(4'h7 - r_q.cnt);
    a7 = r_q.sh[7:1];
    r_d = r_q;
    r_d.rdata = 32'h0000_0000;

    // Software writes; unwritable bits stay zero whatever is written.
    if (reg_wr) begin
      if (sbc_hit(reg_addr, SBC_CTRL_OFS)) begin
        r_d.ctrl = reg_wdata & SBC_CTRL_WMASK; // (RULE10)
        if (!r_q.ctrl[SBC_STRETCH_ENABLE_BIT]) begin
          // Without stretch enable a written zero cannot start a stretch.
          r_d.ctrl[SBC_REL_BIT] = r_q.ctrl[SBC_REL_BIT]
                                  | reg_wdata[SBC_REL_BIT]; // (RULE5)
        end
      end else if (sbc_hit(reg_addr, SBC_SADDR_OFS)) begin
        r_d.saddr = reg_wdata[9:0];
      end else if (sbc_hit(reg_addr, SBC_TXD_OFS)) begin
        r_d.txd = reg_wdata[7:0];
      end
    end

    // Reads answer one cycle later; unmapped offsets read zero.
    if (reg_rd) begin
      if (sbc_hit(reg_addr, SBC_CTRL_OFS)) begin
        r_d.rdata = r_q.ctrl; // (RULE10)
      end else if (sbc_hit(reg_addr, SBC_SADDR_OFS)) begin
        r_d.rdata = {22'h000000, r_q.saddr};
      end else if (sbc_hit(reg_addr, SBC_TXD_OFS)) begin
        r_d.rdata = {24'h000000, r_q.txd};
      end else if (sbc_hit(reg_addr, SBC_RXD_OFS)) begin
        r_d.rdata = {24'h000000, r_q.rxd};
        r_d.rx_full = 1'b0;
      end else if (sbc_hit(reg_addr, SBC_STAT_OFS)) begin
        r_d.rdata = sbc_status(r_q);
      end
    end

    // Slave sequencing; a disabled or halted port drops back to idle.
    if (!active) begin
      r_d.st = SBC_IDLE; // (RULE12) (RULE2)
      r_d.sda_low = 1'b0;
      r_d.ten_ok = 1'b0;
      r_d.cnt = 4'h0;
    end else if (pins.stop) begin
      r_d.st = SBC_IDLE;
      r_d.sda_low = 1'b0;
      r_d.ten_ok = 1'b0;
    end else if (pins.start) begin
      // A repeated start keeps ten_ok so a wide-address read can follow.
      r_d.st = SBC_ADDR;
      r_d.cnt = 4'h0;
      r_d.sda_low = 1'b0;
    end else begin
      if (pins.scl_rise) begin
        unique case (r_q.st)
          SBC_ADDR, SBC_ADDR2, SBC_RX: begin
            r_d.sh = {r_q.sh[6:0], pins.sda};
            r_d.cnt = r_q.cnt + 4'h1;
          end
          SBC_TX: begin
            r_d.cnt = r_q.cnt + 4'h1;
          end
          SBC_TACK: begin
            r_d.nack = pins.sda;
          end
          default: begin
          end
        endcase
      end
      if (pins.scl_fall) begin
        unique case (r_q.st)
          SBC_ADDR: begin
            if (r_q.cnt == 4'h8) begin
              r_d.st = SBC_SKIP;
              r_d.rw = r_q.sh[0];
              if (r_q.ctrl[SBC_WIDE_BIT]) begin
                // Wide prefix 11110 plus the two top address bits.
                if (r_q.sh[7:3] == 5'h1e && r_q.sh[2:1] == r_q.saddr[9:8]
                    && (!r_q.sh[0] || r_q.ten_ok)) begin // (RULE7)
                  r_d.st = SBC_AACK;
                  r_d.sda_low = 1'b1;
                end
              end else if (a7 == r_q.saddr[6:0]
                           && !(r_q.ctrl[SBC_STRICT_BIT]
                                && sbc_reserved(a7))) begin // (RULE6) (RULE7)
                r_d.st = SBC_AACK;
                r_d.sda_low = 1'b1;
              end
            end
          end
          SBC_ADDR2: begin
            if (r_q.cnt == 4'h8) begin
              if (r_q.sh == r_q.saddr[7:0]) begin // (RULE7)
                r_d.st = SBC_AACK;
                r_d.sda_low = 1'b1;
                r_d.ten_ok = 1'b1;
              end else begin
                r_d.st = SBC_SKIP;
              end
            end
          end
          SBC_AACK: begin
            r_d.sda_low = 1'b0;
            r_d.cnt = 4'h0;
            if (r_q.rw) begin
              r_d.st = SBC_TX;
              rel_clr = 1'b1; // (RULE4) (RULE5)
            end else if (r_q.ctrl[SBC_WIDE_BIT] && !r_q.ten_ok) begin
              r_d.st = SBC_ADDR2;
            end else begin
              r_d.st = SBC_RX;
            end
          end
          SBC_RX: begin
            if (r_q.cnt == 4'h8) begin
              r_d.rxd = r_q.sh;
              rx_set = 1'b1;
              r_d.st = SBC_RACK;
              r_d.sda_low = 1'b1;
              rel_clr = r_q.ctrl[SBC_STRETCH_ENABLE_BIT]; // (RULE4)
            end
          end
          SBC_RACK: begin
            r_d.sda_low = 1'b0;
            r_d.cnt = 4'h0;
            r_d.st = SBC_RX;
          end
          SBC_TX: begin
            if (r_q.cnt == 4'h8) begin
              r_d.sda_low = 1'b0;
              r_d.st = SBC_TACK;
            end
          end
          SBC_TACK: begin
            r_d.cnt = 4'h0;
            if (r_q.nack) begin
              r_d.st = SBC_SKIP;
            end else begin
              r_d.st = SBC_TX;
              rel_clr = 1'b1; // (RULE4) (RULE5)
            end
          end
          default: begin
          end
        endcase
      end
      // Transmit data changes only while the clock line is low.
      if (r_q.st == SBC_TX && !pins.scl && r_q.cnt < 4'h8
          && r_d.st == SBC_TX) begin
        r_d.sda_low = ~r_q.txd[bit_idx];
      end
    end

    // Hardware clear beats a software release in the same cycle: a release
    // written before the byte starts belongs to the previous byte.
    if (rel_clr) begin
      r_d.ctrl[SBC_REL_BIT] = 1'b0; // (RULE4) (RULE5)
    end
    // A byte landing in the cycle of the data read keeps its flag set.
    if (rx_set) begin
      r_d.rx_full = 1'b1;
    end

    // Stretch only by extending a low phase, never by cutting a high one.
    r_d.scl_low = active && addressed && !r_d.ctrl[SBC_REL_BIT]
                  && (r_q.scl_low || !pins.scl); // (RULE3)
    if (!active) begin
      r_d.scl_low = 1'b0; // (RULE12)
    end
  end

  // Single state register for this module; sbc_pin_sync keeps its own.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_q <= '{ctrl: SBC_CTRL_RST, saddr: SBC_SADDR_RST, txd: SBC_TXD_RST,
               st: SBC_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // Open-drain drive: enables pull low, levels are always zero.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = r_q.scl_low; // (RULE3)
  assign sda_oe = r_q.sda_low;
  assign reg_rdata = r_q.rdata;

  // Pad control comes straight from the control register.
  assign pins_owned = r_q.ctrl[SBC_ON_BIT]; // (RULE1)
  assign slew_limit_off = r_q.ctrl[SBC_SLEW_BIT]; // (RULE8)
  assign smbus_levels_select = r_q.ctrl[SBC_SMB_BIT]; // (RULE9)

endmodule

// [rtl/sbc_pkg.sv]
/*
  Shared constants and types for the serial bus control block: register
  offsets, control field positions, reset values and the slave states.
  Assumes nothing of its surroundings; sbc_top and sbc_pin_sync import it whole.
*/
package sbc_pkg;

  // Register port address width and byte offsets of the registers.
  localparam int SBC_AW = 8;
  localparam logic [7:0] SBC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SBC_SADDR_OFS = 8'h04;
  localparam logic [7:0] SBC_TXD_OFS = 8'h08;
  localparam logic [7:0] SBC_RXD_OFS = 8'h0c;
  localparam logic [7:0] SBC_STAT_OFS = 8'h10;

  // Field positions inside serial_bus_control.
  localparam int SBC_ON_BIT = 15;
  localparam int SBC_HALT_BIT = 13;
  localparam int SBC_REL_BIT = 12;
  localparam int SBC_STRICT_BIT = 11;
  localparam int SBC_WIDE_BIT = 10;
  localparam int SBC_SLEW_BIT = 9;
  localparam int SBC_SMB_BIT = 8;
  localparam int SBC_STRETCH_ENABLE_BIT = 6;

  // Reset values and the mask of bits that software can write.
  localparam logic [31:0] SBC_CTRL_RST = 32'h0000_1000;
  localparam logic [31:0] SBC_CTRL_WMASK = 32'h0000_bf40;
  localparam logic [9:0] SBC_SADDR_RST = 10'h000;
  localparam logic [7:0] SBC_TXD_RST = 8'h00;
  localparam logic [2:0] SBC_SYNC_RST = 3'h7;

  // Slave bus states.
  typedef enum logic [3:0] {
    SBC_IDLE = 4'h0,
    SBC_ADDR = 4'h1,
    SBC_ADDR2 = 4'h2,
    SBC_AACK = 4'h3,
    SBC_RX = 4'h4,
    SBC_RACK = 4'h5,
    SBC_TX = 4'h6,
    SBC_TACK = 4'h7,
    SBC_SKIP = 4'h8
  } sbc_state_t;

endpackage

// [rtl/sbc_pin_if.sv]
/*
  Carrier between the pin sampler and the control block: filtered line
  levels and one-cycle bus event pulses.
  Assumes a single clock domain, clk_sys, on both ends.
*/
`timescale 1ns/100ps
interface sbc_pin_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport drv (output scl, sda, scl_rise, scl_fall, start, stop);
  modport use_side (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// [rtl/sbc_pin_sync.sv]
/*
  Samples the two bus lines into the clk_sys domain and finds clock edges,
  start and stop conditions.
  Assumes the lines change far slower than clk_sys; pulses last one cycle.
*/
`timescale 1ns/100ps
module sbc_pin_sync import sbc_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Raw bus lines.
  input wire logic scl_i,
  input wire logic sda_i,
  // Filtered levels and events.
  sbc_pin_if.drv pins
);

  typedef struct packed {
    logic [2:0] scl_sh;
    logic [2:0] sda_sh;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } sbc_sync_t;

  sbc_sync_t q;
  sbc_sync_t d;

  // A level counts only once the second and third stages agree; the first
  // stage feeds nothing but the second, so metastability stays contained.
  always_comb begin
    logic scl_new;
    logic sda_new;
    scl_new = q.scl;
    sda_new = q.sda;
    d = q;
    d.scl_sh = {q.scl_sh[1:0], scl_i};
    d.sda_sh = {q.sda_sh[1:0], sda_i};
    if (q.scl_sh[1] == q.scl_sh[2]) begin
      scl_new = q.scl_sh[2];
    end
    if (q.sda_sh[1] == q.sda_sh[2]) begin
      sda_new = q.sda_sh[2];
    end
    d.scl = scl_new;
    d.sda = sda_new;
    d.rise = scl_new & ~q.scl;
    d.fall = ~scl_new & q.scl;
    d.start = q.scl & scl_new & q.sda & ~sda_new;
    d.stop = q.scl & scl_new & ~q.sda & sda_new;
  end

  // Idle bus lines are high, so the filter starts there.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{scl_sh: SBC_SYNC_RST, sda_sh: SBC_SYNC_RST, scl: 1'b1,
             sda: 1'b1, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pins.scl = q.scl;
  assign pins.sda = q.sda;
  assign pins.scl_rise = q.rise;
  assign pins.scl_fall = q.fall;
  assign pins.start = q.start;
  assign pins.stop = q.stop;

endmodule

// [testbench/sbc_top_assertions.sv]
/* Port checker for sbc_top.
   Assumes it is bound into sbc_top and handed the same AW. */
`timescale 1ns/100ps
module sbc_top_assertions import sbc_pkg::*; #(
  parameter int AW = SBC_AW
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Power state and bus lines.
  input wire logic chip_idle,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Pad control.
  input wire logic pins_owned,
  input wire logic slew_limit_off,
  input wire logic smbus_levels_select
);
  logic ctl_wr;
  logic halt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Control writes, and a copy of the halt bit, which has no port of its own.
  assign ctl_wr = reg_wr && (reg_addr == SBC_CTRL_OFS);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      halt_q <= 1'b0;
    end else if (ctl_wr) begin
      halt_q <= reg_wdata[SBC_HALT_BIT];
    end
  end
  // Pin ownership, open drain and pad control follow the register.
  own_follow_a: assert property (ctl_wr |=> pins_owned == $past(reg_wdata[15]))
    else $error("pins_owned does not follow the enable write");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("a bus line was driven high");
  off_release_a: assert property (!pins_owned && $past(!pins_owned) |-> !scl_oe && !sda_oe)
    else $error("disabled port still pulls a line");
  slew_bit_a: assert property (ctl_wr |=> slew_limit_off == $past(reg_wdata[9]))
    else $error("slew_limit_off does not follow its bit");
  smb_bit_a: assert property (ctl_wr |=> smbus_levels_select == $past(reg_wdata[8]))
    else $error("smbus_levels_select does not follow its bit");
  halt_idle_a: assert property (chip_idle && halt_q ##1 chip_idle && halt_q |-> !scl_oe && !sda_oe)
    else $error("halted port drives a line in idle");
  rd_unimpl_a: assert property (reg_rd && reg_addr == SBC_CTRL_OFS |=> reg_rdata[31:16] == 16'h0 && !reg_rdata[14])
    else $error("unimplemented control bits read nonzero");
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  rel_drop_a: assert property (ctl_wr && reg_wdata[12] |=> ##[0:1] !scl_oe)
    else $error("clock still held after release");
  // Main scenarios.
  cover property (ctl_wr && reg_wdata[15]);
  cover property ($rose(scl_oe));
  cover property ($rose(sda_oe));
  cover property ($fell(scl_oe));
endmodule

// [testbench/sbc_bus_model.sv]
/* Behavioural two-wire bus master; both lines have pull-ups.
   Assumes its tasks are called one at a time, starting off a clock edge. */
`timescale 1ns/100ps
module sbc_bus_model (
  // Pull-down enables of the slave.
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Resolved line levels.
  output logic scl_line,
  output logic sda_line,
  // Raised when a stretched clock never came back.
  output logic hung
);
  logic m_scl = 1'b0;
  logic m_sda = 1'b0;
  initial hung = 1'b0;
  // A line reads low while anybody pulls it, else the pull-up wins.
  assign scl_line = !(scl_oe || m_scl);
  assign sda_line = !(sda_oe || m_sda);
  // One bit: data mid-low, long low phase so a stretch is caught in time.
  task automatic pulse(input logic pull, output logic v);
    int n;
    #40 m_sda = pull;
    #120 m_scl = 1'b0;
    n = 0;
    while (!scl_line && n < 4000) begin
      #25 n++;
    end
    if (n >= 4000) hung = 1'b1;
    #35 v = sda_line;
    #5 m_scl = 1'b1;
  endtask
  // The odd offset keeps line changes away from the sampling clock edges.
  task automatic start();
    #7 m_sda = 1'b1;
    #75 m_scl = 1'b1;
  endtask
  task automatic stop();
    #40 m_sda = 1'b1;
    #120 m_scl = 1'b0;
    #50 m_sda = 1'b0;
    #100;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) pulse(!b[i], v);
    pulse(1'b0, ack);
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) pulse(1'b0, b[i]);
    pulse(!nack, v);
  endtask
endmodule

// [testbench/tb_i2c_control_config.sv]
/* Self-checking bench for sbc_top with a bus master model.
   Assumes the package constants for offsets and reset value. */
`timescale 1ns/100ps
module tb_i2c_control_config import sbc_pkg::*; ();
  typedef struct {logic [31:0] wd; logic [31:0] ex;} sbc_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic chip_idle = 1'b0;
  logic [31:0] reg_rdata;
  logic scl_line, sda_line, scl_oe, sda_oe, pins_owned, slew_off, smb_sel, hung, ack;
  logic [7:0] rx_b;
  int error_cnt = 0;
  int checked = 0;
  int n;
  // Rows switch stretch enable in pairs (off, on, off) so both release-bit write modes are seen.
  sbc_row_t rows[6] = '{'{32'hffff_ffbf, 32'h0000_bf00}, '{32'h0, 32'h0000_1000},
    '{32'h40, 32'h1040}, '{32'h1340, 32'h1340}, '{32'h200, 32'h200}, '{32'h1100, 32'h1100}};
  // Free-running system clock.
  always #12.5 clk_sys = !clk_sys;
  sbc_top u_sbc_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chip_idle(chip_idle), .scl_i(scl_line), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe), .pins_owned(pins_owned),
    .slew_limit_off(slew_off), .smbus_levels_select(smb_sel));
  sbc_bus_model u_sbc_bus_model (.scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl_line(scl_line), .sda_line(sda_line), .hung(hung));
  // Verdict in one place; every timeout ends up here as well.
  task automatic results();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    u_sbc_bus_model.start();
    u_sbc_bus_model.send_byte(b, ack);
    check({31'h0, ack}, {31'h0, exp_ack});
    u_sbc_bus_model.stop();
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(SBC_CTRL_OFS, SBC_CTRL_RST);
    check({31'h0, pins_owned}, 32'h0);
    foreach (rows[i]) begin
      wr(SBC_CTRL_OFS, rows[i].wd);
      rdc(SBC_CTRL_OFS, rows[i].ex);
      check({pins_owned, slew_off, smb_sel}, {rows[i].ex[15], rows[i].ex[9:8]});
    end
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0);
    $display("test registers done");
    // A 7-bit read: the slave stretches until software loads data and releases.
    wr(SBC_SADDR_OFS, 32'h50);
    wr(SBC_CTRL_OFS, 32'h9000);
    fork
      begin
        xfer_read: begin
          u_sbc_bus_model.start();
          u_sbc_bus_model.send_byte(8'ha1, ack);
          check({31'h0, ack}, 32'h0);
          u_sbc_bus_model.recv_byte(1'b1, rx_b);
          u_sbc_bus_model.stop();
        end
      end
      begin
        n = 0;
        while (scl_oe !== 1'b1 && n < 2000) begin
          @(posedge clk_sys);
          n++;
        end
        if (n >= 2000) begin
          error_cnt++;
          results();
        end
        check({31'h0, scl_oe}, 32'h1);
        rdc(SBC_CTRL_OFS, 32'h8000);
        wr(SBC_TXD_OFS, 32'ha5);
        wr(SBC_CTRL_OFS, 32'h9000);
      end
    join
    check({24'h0, rx_b}, 32'ha5);
    $display("test stretch done");
    wr(SBC_SADDR_OFS, 32'h03);
    for (int s = 0; s < 2; s++) begin
      wr(SBC_CTRL_OFS, 32'h9000 | (32'(s) << 11));
      xfer(8'h06, s[0]);
    end
    $display("test strict done");
    wr(SBC_SADDR_OFS, 32'h250);
    wr(SBC_CTRL_OFS, 32'h9400);
    xfer(8'ha0, 1'b1);
    u_sbc_bus_model.start();
    u_sbc_bus_model.send_byte(8'hf4, ack);
    check({31'h0, ack}, 32'h0);
    u_sbc_bus_model.send_byte(8'h50, ack);
    check({31'h0, ack}, 32'h0);
    u_sbc_bus_model.send_byte(8'h3c, ack);
    check({31'h0, ack}, 32'h0);
    u_sbc_bus_model.stop();
    rdc(SBC_RXD_OFS, 32'h3c);
    $display("test wide done");
    wr(SBC_SADDR_OFS, 32'h50);
    wr(SBC_CTRL_OFS, 32'hb000);
    chip_idle <= 1'b1;
    xfer(8'ha0, 1'b1);
    @(posedge clk_sys);
    chip_idle <= 1'b0;
    xfer(8'ha0, 1'b0);
    $display("test halt done");
    wr(SBC_CTRL_OFS, 32'h1000);
    @(posedge clk_sys);
    xfer(8'ha0, 1'b1);
    check({31'h0, pins_owned}, 32'h0);
    $display("test disable done");
    wr(SBC_CTRL_OFS, 32'hffff_ffff);
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(SBC_CTRL_OFS, SBC_CTRL_RST);
    check({31'h0, hung}, 32'h0);
    $display("test reset done");
    results();
  end
endmodule
bind sbc_top sbc_top_assertions #(.AW(AW)) u_sbc_top_assertions (.clk_sys(clk_sys),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_idle(chip_idle), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .pins_owned(pins_owned), .slew_limit_off(slew_limit_off),
  .smbus_levels_select(smbus_levels_select));
